// [poster_defines.svh]
// Constants for the posted interrupt descriptor poster.
//
// Contract
// - Legacy 8-bit mode takes the notify target from descriptor bits 303:296.
// - Extended 32-bit mode takes the notify target from descriptor bits 319:288.
// - Every notification uses descriptor bits 279:272 as its physical vector.
// - Notifications go out edge triggered with the level indication asserted.
// - Descriptor bits 255:0 are the request map, bit n for vector n.
// - A posting counts as done once its request bit is written back set.
// - Outstanding flag bit 256 clear on posting: set it and notify.
// - Outstanding flag already set on posting: send no notification.
// - Suppress flag bit 257 applies only to non-urgent postings; one suppresses.
// - Non-urgent means posting-mode bit set and urgency bit clear in the entry.
// - Suppressed non-urgent posting still sets its request bit, leaves the flag.
// - Entry bits 23:16 give the virtual vector that selects the request bit.
// - Entry bit 15 set means posted; clear means the poster is not used.
// - Entry bit 14 set marks the posting urgent, so suppression does not apply.
// - Entry bits 63:38 give descriptor address bits 31:6, low six bits zero.
`ifndef POSTER_DEFINES_SVH
`define POSTER_DEFINES_SVH

`define DESC_MAP_MSB      255
`define DESC_ON_BIT       256
`define DESC_SN_BIT       257
`define DESC_NV_MSB       279
`define DESC_NV_LSB       272
`define DESC_DST_MSB      319
`define DESC_DST_LSB      288
`define DESC_LEG_MSB      303
`define DESC_LEG_LSB      296
`define ENTRY_ADDR_MSB    63
`define ENTRY_ADDR_LSB    38
`define ENTRY_VV_MSB      23
`define ENTRY_VV_LSB      16
`define ENTRY_MODE_BIT    15
`define ENTRY_URG_BIT     14
`define DESC_ALIGN_ZERO   6'h00

`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_MASK          8'h08
`define REG_COUNT         8'h0C
`define REG_STATE         8'h10

`define CTRL_ENABLE_BIT   0
`define CTRL_EXTMODE_BIT  1
`define CTRL_RESET        32'h00000001
`define MASK_RESET        32'h00000000

`define EV_POSTED_BIT     0
`define EV_NOTIFY_BIT     1
`define EV_SUPPRESS_BIT   2
`define EV_BYPASS_BIT     3
`define EV_HELD_BIT       4

`define TRIGGER_EDGE      1'b1
`define LEVEL_ASSERTED    1'b1

`endif

// [poster_pkg.sv]
// Types shared by the posted interrupt descriptor poster.
package poster_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_READ   = 2'h1,
    ST_WRITE  = 2'h3,
    ST_NOTIFY = 2'h2
  } state_t;

  typedef logic [511:0] desc_t;

endpackage

// [post_calc_if.sv]
// Carrier between the poster sequencer and its descriptor update logic.
interface post_calc_if;
  poster_pkg::desc_t old_desc;
  logic [7:0]        vector;
  logic              urgent;
  logic              ext_mode;
  poster_pkg::desc_t new_desc;
  logic              notify;
  logic              suppressed;
  logic [31:0]       target;
  logic [7:0]        notify_vec;

  modport requester (
    output old_desc,
    output vector,
    output urgent,
    output ext_mode,
    input  new_desc,
    input  notify,
    input  suppressed,
    input  target,
    input  notify_vec
  );

  modport calc (
    input  old_desc,
    input  vector,
    input  urgent,
    input  ext_mode,
    output new_desc,
    output notify,
    output suppressed,
    output target,
    output notify_vec
  );
endinterface

// [post_calc.sv]
// Descriptor update logic: sets the request bit and decides on notification.
`include "poster_defines.svh"

module post_calc (
  post_calc_if.calc bus
);

  always_comb begin
    bus.new_desc = bus.old_desc;
    // Request map bit for the virtual vector is always set.
    bus.new_desc[bus.vector] = 1'b1;
    // Suppression only for non-urgent postings.
    bus.suppressed = !bus.urgent && bus.old_desc[`DESC_SN_BIT];
    // Notify only if no notification is outstanding and not suppressed.
    bus.notify = !bus.suppressed && !bus.old_desc[`DESC_ON_BIT];
    if (bus.notify) begin
      bus.new_desc[`DESC_ON_BIT] = 1'b1;
    end
    if (bus.ext_mode) begin
      bus.target = bus.old_desc[`DESC_DST_MSB:`DESC_DST_LSB];
    end else begin
      bus.target = {24'h000000, bus.old_desc[`DESC_LEG_MSB:`DESC_LEG_LSB]};
    end
    bus.notify_vec = bus.old_desc[`DESC_NV_MSB:`DESC_NV_LSB];
  end

endmodule

// [posted_interrupt_descriptor_poster.sv]
// Posts remapped interrupts into memory descriptors and sends notifications.
//
// Our own choices: the address map and the address-and-strobe port.
`include "poster_defines.svh"

module posted_interrupt_descriptor_poster (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         req_valid,
  input  wire logic [63:0]  req_entry,
  output logic              req_ready,
  output logic              mem_req,
  output logic              mem_we,
  output logic              mem_lock,
  output logic [31:0]       mem_addr,
  output logic [511:0]      mem_wdata,
  input  wire logic         mem_ack,
  input  wire logic [511:0] mem_rdata,
  output logic              notify_valid,
  output logic [31:0]       notify_target,
  output logic [7:0]        notify_vector,
  output logic              notify_edge,
  output logic              notify_level,
  input  wire logic         notify_ready,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  output logic              irq
);

  poster_pkg::state_t state;
  poster_pkg::state_t next_state;
  post_calc_if        calc_bus ();

  logic [31:0] ctrl;
  logic [31:0] status;
  logic [31:0] next_status;
  logic [31:0] mask;
  logic [15:0] post_count;
  logic [15:0] notify_count;
  logic [7:0]  vector;
  logic        urgent;
  logic        notify_due;
  logic        suppress_seen;
  logic        take;
  logic        posted_done;
  logic        notify_done;
  logic        bypass_seen;
  logic        held_seen;

  assign take        = req_valid && req_ready;
  assign posted_done = (state == poster_pkg::ST_WRITE) && mem_ack;
  assign notify_done = notify_valid && notify_ready;
  assign bypass_seen = take && !req_entry[`ENTRY_MODE_BIT];
  assign held_seen   = posted_done && !notify_due && !suppress_seen;

  assign calc_bus.old_desc = mem_rdata;
  assign calc_bus.vector   = vector;
  assign calc_bus.urgent   = urgent;
  assign calc_bus.ext_mode = ctrl[`CTRL_EXTMODE_BIT];

  post_calc u_calc (
    .bus (calc_bus.calc)
  );

  // Sequencer: locked read, write back, then optional notification.
  always_comb begin
    next_state = state;
    unique case (state)
      poster_pkg::ST_IDLE: begin
        if (take && req_entry[`ENTRY_MODE_BIT]) begin
          next_state = poster_pkg::ST_READ;
        end
      end
      poster_pkg::ST_READ: begin
        if (mem_ack) begin
          next_state = poster_pkg::ST_WRITE;
        end
      end
      poster_pkg::ST_WRITE: begin
        if (mem_ack) begin
          if (notify_due) begin
            next_state = poster_pkg::ST_NOTIFY;
          end else begin
            next_state = poster_pkg::ST_IDLE;
          end
        end
      end
      poster_pkg::ST_NOTIFY: begin
        if (notify_ready) begin
          next_state = poster_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= poster_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Requests are accepted only while idle and enabled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (next_state == poster_pkg::ST_IDLE) && !take
                   && ctrl[`CTRL_ENABLE_BIT];
    end
  end

  // Capture of the entry fields that steer the posting.
  always_ff @(posedge mclk) begin
    if (rst) begin
      vector   <= 8'h00;
      urgent   <= 1'b0;
      mem_addr <= 32'h00000000;
    end else if (take) begin
      vector   <= req_entry[`ENTRY_VV_MSB:`ENTRY_VV_LSB];
      urgent   <= req_entry[`ENTRY_URG_BIT];
      mem_addr <= {req_entry[`ENTRY_ADDR_MSB:`ENTRY_ADDR_LSB], `DESC_ALIGN_ZERO};
    end
  end

  // Memory port: the lock spans the read and the write back.
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_req  <= 1'b0;
      mem_we   <= 1'b0;
      mem_lock <= 1'b0;
    end else begin
      mem_req  <= (next_state == poster_pkg::ST_READ) || (next_state == poster_pkg::ST_WRITE);
      mem_we   <= next_state == poster_pkg::ST_WRITE;
      mem_lock <= (next_state == poster_pkg::ST_READ) || (next_state == poster_pkg::ST_WRITE);
    end
  end

  // Updated descriptor and notification decision taken from the locked read.
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_wdata     <= '0;
      notify_due    <= 1'b0;
      suppress_seen <= 1'b0;
      notify_target <= 32'h00000000;
      notify_vector <= 8'h00;
    end else if ((state == poster_pkg::ST_READ) && mem_ack) begin
      mem_wdata     <= calc_bus.new_desc;
      notify_due    <= calc_bus.notify;
      suppress_seen <= calc_bus.suppressed;
      notify_target <= calc_bus.target;
      notify_vector <= calc_bus.notify_vec;
    end
  end

  // Notification strobe holds until the interrupt controller takes it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      notify_valid <= 1'b0;
    end else begin
      notify_valid <= next_state == poster_pkg::ST_NOTIFY;
    end
  end

  // Notifications are always edge triggered with the level asserted.
  always_ff @(posedge mclk) begin
    if (rst) begin
      notify_edge  <= `TRIGGER_EDGE;
      notify_level <= `LEVEL_ASSERTED;
    end else begin
      notify_edge  <= `TRIGGER_EDGE;
      notify_level <= `LEVEL_ASSERTED;
    end
  end

  // Control and mask registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      mask <= `MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTRL) begin
        ctrl <= {30'h00000000, reg_wdata[1:0]};
      end
      if (reg_addr == `REG_MASK) begin
        mask <= {27'h0000000, reg_wdata[4:0]};
      end
    end
  end

  // Sticky event bits: a new event wins over a write-one clear.
  always_comb begin
    next_status = status;
    if (reg_wr && (reg_addr == `REG_STATUS)) begin
      next_status = status & ~reg_wdata;
    end
    next_status[`EV_POSTED_BIT]   = next_status[`EV_POSTED_BIT] | posted_done;
    next_status[`EV_NOTIFY_BIT]   = next_status[`EV_NOTIFY_BIT] | notify_done;
    next_status[`EV_SUPPRESS_BIT] = next_status[`EV_SUPPRESS_BIT] | (posted_done && suppress_seen);
    next_status[`EV_BYPASS_BIT]   = next_status[`EV_BYPASS_BIT] | bypass_seen;
    next_status[`EV_HELD_BIT]     = next_status[`EV_HELD_BIT] | held_seen;
    next_status[31:5]             = 27'h0000000;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= 32'h00000000;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

  // Counters of completed postings and of notifications sent.
  always_ff @(posedge mclk) begin
    if (rst) begin
      post_count   <= 16'h0000;
      notify_count <= 16'h0000;
    end else begin
      if (posted_done) begin
        post_count <= post_count + 16'h0001;
      end
      if (notify_done) begin
        notify_count <= notify_count + 16'h0001;
      end
    end
  end

  // Read data stand for exactly one cycle after the read strobe.
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL:   reg_rdata <= ctrl;
        `REG_STATUS: reg_rdata <= status;
        `REG_MASK:   reg_rdata <= mask;
        `REG_COUNT:  reg_rdata <= {notify_count, post_count};
        `REG_STATE:  reg_rdata <= {22'h000000, vector, state};
        default:     reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// [poster_sva.sv]
// Checker watching the descriptor poster at its top-level ports.
module poster_sva (
  input wire logic         mclk,
  input wire logic         rst,
  input wire logic         req_valid,
  input wire logic [63:0]  req_entry,
  input wire logic         req_ready,
  input wire logic         mem_req,
  input wire logic         mem_we,
  input wire logic         mem_lock,
  input wire logic [31:0]  mem_addr,
  input wire logic [511:0] mem_wdata,
  input wire logic         mem_ack,
  input wire logic [511:0] mem_rdata,
  input wire logic         notify_valid,
  input wire logic [7:0]   notify_vector,
  input wire logic         notify_edge,
  input wire logic         notify_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [511:0] d_q;
  logic [7:0]   vv_q;
  logic         urg_q;
  logic         sup;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  assign sup = !urg_q && d_q[257];
  always_ff @(posedge mclk) begin
    if (req_valid && req_ready) begin
      vv_q <= req_entry[23:16];
      urg_q <= req_entry[14];
    end
  end
  always_ff @(posedge mclk) begin
    if (mem_req && !mem_we && mem_ack) begin
      d_q <= mem_rdata;
    end
  end
  AST_EDGE: assert property (notify_edge && notify_level)
    else $error("notify not edge asserted");
  AST_ADDR: assert property (req_valid && req_ready && req_entry[15] |=>
    mem_req && mem_lock && !mem_we && mem_addr == {$past(req_entry[63:38]), 6'h00})
    else $error("bad descriptor address");
  AST_BYPASS: assert property (req_valid && req_ready && !req_entry[15] |=>
    !mem_req && !req_ready ##1 !mem_req && req_ready) else $error("bypass wrong");
  AST_LOCK: assert property (mem_req |-> mem_lock) else $error("unlocked access");
  AST_RMW: assert property (mem_req && !mem_we && mem_ack |=> mem_req && mem_we)
    else $error("no write after read");
  AST_HOLD: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
    else $error("write data moved");
  AST_BIT: assert property (mem_req && mem_we |-> mem_wdata[vv_q])
    else $error("request bit not set");
  AST_FLAG: assert property (mem_req && mem_we |-> mem_wdata[256] == (d_q[256] || !sup))
    else $error("flag wrong");
  AST_NOTE: assert property (mem_req && mem_we && mem_ack |=>
    notify_valid == (!d_q[256] && !sup)) else $error("notify decision wrong");
  AST_VEC: assert property (notify_valid |-> notify_vector == d_q[279:272])
    else $error("wrong notify vector");
endmodule
bind posted_interrupt_descriptor_poster poster_sva poster_sva_i (.mclk, .rst, .req_valid,
  .req_entry, .req_ready, .mem_req, .mem_we, .mem_lock, .mem_addr, .mem_wdata, .mem_ack,
  .mem_rdata, .notify_valid, .notify_vector, .notify_edge, .notify_level);

// [poster_mem_model.sv]
// Partner model: coherent memory with one descriptor and a notification sink.
module poster_mem_model (
  input wire logic         mclk,
  input wire logic         slow,
  input wire logic         mem_req,
  input wire logic         mem_we,
  input wire logic [511:0] mem_wdata,
  output logic             mem_ack,
  output logic [511:0]     mem_rdata,
  output logic             notify_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [511:0] desc;
  logic [1:0]   waited;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = '0;
    notify_ready = 1'b0;
    waited = 2'h0;
    desc = '0;
  end
  // Read data stand only with the acknowledge; otherwise the bus toggles.
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    notify_ready <= slow ? ~notify_ready : 1'b1;
    if (mem_req && !mem_ack) begin
      waited <= waited + 2'h1;
      if (!slow || waited == 2'h3) begin
        mem_ack <= 1'b1;
        waited <= 2'h0;
        if (mem_we) begin
          desc <= mem_wdata;
        end else begin
          mem_rdata <= desc;
        end
      end
    end
  end
endmodule

// [posted_interrupt_descriptor_poster_tb.sv]
// Self-checking bench for the descriptor poster with its memory partner.
module posted_interrupt_descriptor_poster_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk, rst, req_valid, req_ready, mem_req, mem_we, mem_lock, mem_ack;
  logic         notify_valid, notify_edge, notify_level, notify_ready;
  logic         reg_wr, reg_rd, irq, rd_d, ext, slow;
  logic [4:0]   mask;
  logic [7:0]   reg_addr, notify_vector;
  logic [31:0]  mem_addr, notify_target, reg_wdata, reg_rdata;
  logic [63:0]  req_entry;
  logic [511:0] mem_wdata, mem_rdata;
  logic [511:0] q_desc[$];
  logic [41:0]  q_note[$];
  logic [32:0]  q_reg[$];
  int           fails, n_compared, cycles;
  posted_interrupt_descriptor_poster posted_interrupt_descriptor_poster_i (.mclk, .rst,
    .req_valid, .req_entry, .req_ready, .mem_req, .mem_we, .mem_lock, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .notify_valid, .notify_target, .notify_vector, .notify_edge,
    .notify_level, .notify_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  poster_mem_model poster_mem_model_i (.mclk, .slow, .mem_req, .mem_we, .mem_wdata,
    .mem_ack, .mem_rdata, .notify_ready);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(string what, logic [511:0] e, logic [511:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic cmp_desc(logic [511:0] e, logic [511:0] g);
    chk("descriptor", e, g);
  endtask
  task automatic cmp_note(logic [41:0] e, logic [41:0] g);
    chk("notification", 512'(e), 512'(g));
  endtask
  task automatic cmp_reg(logic [32:0] e, logic [32:0] g);
    chk("irq and read data", 512'(e), 512'(g));
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] e);
    q_reg.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic post(logic [7:0] vv, logic md, logic urgency_bit, logic sn, logic on);
    logic [511:0] d;
    logic [511:0] n;
    logic [31:0]  tgt;
    logic [4:0]   ev;
    logic         sup;
    int           k;
    for (k = 0; k < 8; k++) begin
      d[k*32 +: 32] = $urandom;
    end
    d[511:256] = '0;
    tgt = ext ? $urandom : {24'h0, 8'($urandom)};
    d[319:288] = ext ? tgt : {16'h0, tgt[7:0], 8'h00};
    d[279:272] = 8'($urandom);
    d[257:256] = {sn, on};
    poster_mem_model_i.desc = d;
    sup = !urgency_bit && sn;
    n = d;
    n[vv] = 1'b1;
    n[256] = on || !sup;
    ev = md ? {on && !sup, 1'b0, sup, !on && !sup, 1'b1} : 5'h08;
    if (md) begin
      q_desc.push_back(n);
    end
    if (md && !on && !sup) begin
      q_note.push_back({tgt, d[279:272], 2'b11});
    end
    wr(8'h04, 32'h1F);
    reg_wr <= 1'b0;
    req_entry <= {26'($urandom), 14'h0, vv, md, urgency_bit, 14'h0};
    req_valid <= 1'b1;
    k = 0;
    do @(posedge mclk); while (req_ready !== 1'b1 && ++k < 60);
    req_valid <= 1'b0;
    k = 0;
    do @(posedge mclk); while (req_ready !== 1'b1 && ++k < 90);
    if (!(on && sup)) begin
      rd(8'h04, {|(ev & mask), 27'h0, ev});
    end
  endtask
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    if (mem_req === 1'b1 && mem_we === 1'b1 && mem_ack) begin
      cmp_desc(q_desc.pop_front(), mem_wdata);
    end
    if (notify_valid === 1'b1 && notify_ready) begin
      cmp_note(q_note.pop_front(), {notify_target, notify_vector, notify_edge, notify_level});
    end
    if (rd_d) begin
      cmp_reg(q_reg.pop_front(), {irq, reg_rdata});
    end
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_entry = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    ext = 1'b0;
    slow = 1'b0;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    void'($urandom(32'h2EA4));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h00, 33'h000000001);
    rd(8'h08, 33'h0);
    rd(8'h40, 33'h0);
    mask = 5'($urandom);
    wr(8'h08, {27'h0, mask});
    rd(8'h08, {28'h0, mask});
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      ext <= i[0];
      slow <= i[1];
      wr(8'h00, {30'h0, i[0], 1'b1});
      for (int c = 0; c < 9; c++) begin
        post(c == 0 ? 8'h00 : c == 7 ? 8'hFF : 8'($urandom), c < 8, c[0], c[1], c[2]);
      end
      $display("test mode %0d done", i);
    end
    wr(8'h04, 32'h1F);
    rd(8'h04, 33'h0);
    reg_rd <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("leftover", 512'h0, 512'(q_desc.size() + q_note.size() + q_reg.size()));
    end_sim();
  end
endmodule
